// *** pkg/diag_flags_consts.svh ***
`ifndef DIAG_FLAGS_CONSTS_SVH
`define DIAG_FLAGS_CONSTS_SVH
// Operation
// - modulator saturation of the high channel sets bit 5, of the low channel bit 2.
// - filter overrange before correction sets bit 4 (high channel) or bit 1 (low channel).
// - an out-of-limit result is clamped and sets bit 3 (high channel) or bit 0 (low).
// - each check type except the clock switchover has its own enable bit and raises its flag only while enabled.
// - the check enable register resets to 0xFE, reference detect off.
// - a periodic checksum over register contents sets bit 5 of flags one on mismatch.
// - a periodic checksum over fuse contents sets bit 4 of flags one on mismatch.
// - serial faults set clock count bit 3, bad read bit 2, bad write bit 1, crc bit 0.
// - enables one sit at the flag positions and reset to 0x3E, serial crc check off.
// - a detected reset sets bit 5 and a failed clock switchover bit 4 of flags two.
// - supply faults set analog one bit 2, analog two bit 1, digital bit 0 of flags two.
// - supply monitor select at [3:2] picks none, analog, digital or all; reset 0x3C.
// - trip detect select at [1:0] picks none, analog one, analog two, digital; reset 00.

// register indices, byte address is four times the index
`define IDX_SAT_FLAGS 8'h57
`define IDX_CHK_EN 8'h58
`define IDX_GEN1_FLAGS 8'h59
`define IDX_GEN1_EN 8'h5A
`define IDX_GEN2_FLAGS 8'h5B
`define IDX_GEN2_EN 8'h5C

// reset values
`define RST_FLAGS 8'h00
`define RST_CHK_EN 8'hFE
`define RST_GEN1_EN 8'h3E
`define RST_GEN2_EN 8'h3C

// check enable bit positions
`define BIT_OUT_CLAMP_EN 7
`define BIT_FILTER_EN 6
`define BIT_MOD_EN 5

// saturation flag bit positions per channel pair
`define BIT_HI_MOD 5
`define BIT_HI_FILTER 4
`define BIT_HI_CLAMP 3
`define BIT_LO_MOD 2
`define BIT_LO_FILTER 1
`define BIT_LO_CLAMP 0

// general flags one
`define BIT_MAP_CRC 5
`define BIT_FUSE_CRC 4
`define GEN1_MASK 8'h3F

// general flags two / enables two
`define BIT_RESET_DET 5
`define BIT_CLK_SWITCH 4
`define BIT_AREG1 2
`define BIT_AREG2 1
`define BIT_DREG 0
`define GEN2_FLAG_MASK 8'h37
`define GEN2_EN_MASK 8'h3F
`define SUPPLY_SEL_LSB 2

// checksum
`define CRC_POLY 8'h07
`define CHECK_PERIOD 1024
`endif

// *** pkg/diag_flags_pkg.sv ***
package diag_flags_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {SUPPLY_NONE, SUPPLY_ANALOG, SUPPLY_DIGITAL, SUPPLY_ALL} supply_sel_t;
   typedef enum logic [1:0] {TRIP_NONE, TRIP_AREG1, TRIP_AREG2, TRIP_DREG} trip_sel_t;
endpackage : diag_flags_pkg

// *** hw/adc_diagnostic_error_flags.sv ***
`timescale 1ns/1ps
`include "diag_flags_consts.svh"
module adc_diagnostic_error_flags
   import diag_flags_pkg::*;
#(
   parameter int RAW_W = 26,
   parameter int OUT_W = 24,
   parameter int FUSE_W = 32,
   parameter int CHECK_PERIOD = `CHECK_PERIOD
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // channel events, index 0 low channel, 1 high channel
   input wire logic [1:0] modSatEvent,
   input wire logic [1:0] filterOverEvent,
   input wire logic [1:0] resultValid,
   input wire logic [2*RAW_W-1:0] rawResult,
   output logic [2*OUT_W-1:0] clampedResult,
   output logic [1:0] clampedValid,
   // serial port faults: crc, bad write, bad read, clock count
   input wire logic [3:0] serialFault,
   // fuse contents and stored checksum
   input wire logic [FUSE_W-1:0] fuseData,
   input wire logic [7:0] fuseCrc,
   // general events
   input wire logic resetSeenEvent,
   input wire logic clockSwitchFailEvent,
   // supply monitor pins: digital, analog two, analog one
   input wire logic [2:0] supplyFaultPin,
   // check controls towards the analog side
   output logic [7:0] checkEnable,
   output logic [1:0] supplyMonitorSelect,
   output logic [1:0] tripDetectSelect
);

   byte_t satFlags_reg;
   byte_t chkEn_reg;
   byte_t gen1Flags_reg;
   byte_t gen1En_reg;
   byte_t gen2Flags_reg;
   byte_t gen2En_reg;
   byte_t satSet;
   byte_t gen1Set;
   byte_t gen2Set;
   byte_t mapCrc_reg;
   byte_t mapCrc_next;
   byte_t readData;
   logic [31:0] periodCnt_reg;
   logic checkTick;
   logic [7:0] wordIndex;
   logic mapped;
   logic setupPhase;
   logic accessDone;
   logic wrDone;
   logic rdDone;
   logic [1:0] outClampHit;
   logic [2:0] supplyStable;
   logic mapCrcBad;
   logic fuseCrcBad;
   supply_sel_t supplySel;
   byte_t satKeep;
   byte_t gen2Keep;
   logic wrSeen_reg;

   function automatic byte_t crc8(input logic [FUSE_W-1:0] data, input int nbytes);
      byte_t c;
      c = 8'h00;
      for (int b = 0; b < nbytes; b++) begin
         c = c ^ data[b*8 +: 8];
         for (int k = 0; k < 8; k++) begin
            c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
         end
      end
      return c;
   endfunction : crc8

   // bus decode
   assign wordIndex = paddr[9:2];
   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable;
   assign wrDone = accessDone && pwrite && mapped && pstrb[0];
   assign rdDone = accessDone && !pwrite && mapped;
   assign pready = 1'b1;

   always_comb begin
      mapped = 1'b0;
      readData = 8'h00;
      if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00) begin
         case (wordIndex)
            `IDX_SAT_FLAGS: begin
               mapped = 1'b1;
               readData = satFlags_reg;
            end
            `IDX_CHK_EN: begin
               mapped = 1'b1;
               readData = chkEn_reg;
            end
            `IDX_GEN1_FLAGS: begin
               mapped = 1'b1;
               readData = gen1Flags_reg;
            end
            `IDX_GEN1_EN: begin
               mapped = 1'b1;
               readData = gen1En_reg;
            end
            `IDX_GEN2_FLAGS: begin
               mapped = 1'b1;
               readData = gen2Flags_reg;
            end
            `IDX_GEN2_EN: begin
               mapped = 1'b1;
               readData = gen2En_reg;
            end
            default: begin
               mapped = 1'b0;
               readData = 8'h00;
            end
         endcase
      end
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata <= {24'h00_0000, readData};
         pslverr <= !mapped;
      end else if (accessDone) begin
         pslverr <= 1'b0;
      end
   end

   // enable registers
   always_ff @(posedge clk) begin
      if (srst) begin
         chkEn_reg <= `RST_CHK_EN;
      end else if (wrDone && wordIndex == `IDX_CHK_EN) begin
         chkEn_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gen1En_reg <= `RST_GEN1_EN;
      end else if (wrDone && wordIndex == `IDX_GEN1_EN) begin
         gen1En_reg <= pwdata[7:0] & `GEN1_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gen2En_reg <= `RST_GEN2_EN;
      end else if (wrDone && wordIndex == `IDX_GEN2_EN) begin
         gen2En_reg <= pwdata[7:0] & `GEN2_EN_MASK;
      end
   end

   assign checkEnable = chkEn_reg;
   assign supplyMonitorSelect = gen2En_reg[`SUPPLY_SEL_LSB +: 2];
   assign tripDetectSelect = gen2En_reg[1:0];
   assign supplySel = supply_sel_t'(gen2En_reg[`SUPPLY_SEL_LSB +: 2]);

   // result clamp per channel
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_clamp
         logic signed [RAW_W-1:0] raw;
         logic over;
         logic under;
         assign raw = rawResult[ch*RAW_W +: RAW_W];
         assign over = raw > $signed({{(RAW_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}});
         assign under = raw < $signed({{(RAW_W-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}});
         assign outClampHit[ch] = resultValid[ch] && (over || under);

         always_ff @(posedge clk) begin
            if (srst) begin
               clampedResult[ch*OUT_W +: OUT_W] <= '0;
               clampedValid[ch] <= 1'b0;
            end else begin
               clampedValid[ch] <= resultValid[ch];
               if (resultValid[ch]) begin
                  if (over) begin
                     clampedResult[ch*OUT_W +: OUT_W] <= {1'b0, {(OUT_W-1){1'b1}}};
                  end else if (under) begin
                     clampedResult[ch*OUT_W +: OUT_W] <= {1'b1, {(OUT_W-1){1'b0}}};
                  end else begin
                     clampedResult[ch*OUT_W +: OUT_W] <= raw[OUT_W-1:0];
                  end
               end
            end
         end
      end
   endgenerate

   // supply fault pins, three stages, counted when stages two and three agree
   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         logic [2:0] stage;
         always_ff @(posedge clk) begin
            if (srst) begin
               stage <= 3'b000;
            end else begin
               stage <= {stage[1:0], supplyFaultPin[i]};
            end
         end
         always_ff @(posedge clk) begin
            if (srst) begin
               supplyStable[i] <= 1'b0;
            end else if (stage[1] == stage[2]) begin
               supplyStable[i] <= stage[2];
            end
         end
      end
   endgenerate

   // periodic checksum tick
   always_ff @(posedge clk) begin
      if (srst) begin
         periodCnt_reg <= 32'h0000_0000;
      end else if (checkTick) begin
         periodCnt_reg <= 32'h0000_0000;
      end else begin
         periodCnt_reg <= periodCnt_reg + 32'h0000_0001;
      end
   end

   assign checkTick = periodCnt_reg == 32'(CHECK_PERIOD - 1);

   // reference checksum over the writable registers, refreshed every cycle
   assign mapCrc_next = crc8(FUSE_W'({chkEn_reg, gen1En_reg, gen2En_reg}), 3);

   always_ff @(posedge clk) begin
      if (srst) begin
         mapCrc_reg <= 8'h00;
      end else begin
         mapCrc_reg <= mapCrc_next;
      end
   end

   // a landed write moves the reference one cycle late, as does reset
   always_ff @(posedge clk) begin
      if (srst) begin
         wrSeen_reg <= 1'b1;
      end else begin
         wrSeen_reg <= wrDone;
      end
   end

   assign mapCrcBad = checkTick && (mapCrc_reg != mapCrc_next) && !wrSeen_reg;
   assign fuseCrcBad = checkTick && (crc8(fuseData, FUSE_W / 8) != fuseCrc);

   // flag set terms, each gated by its enable except the clock switchover
   always_comb begin
      satSet = 8'h00;
      satSet[`BIT_HI_MOD] = modSatEvent[1] && chkEn_reg[`BIT_MOD_EN];
      satSet[`BIT_LO_MOD] = modSatEvent[0] && chkEn_reg[`BIT_MOD_EN];
      satSet[`BIT_HI_FILTER] = filterOverEvent[1] && chkEn_reg[`BIT_FILTER_EN];
      satSet[`BIT_LO_FILTER] = filterOverEvent[0] && chkEn_reg[`BIT_FILTER_EN];
      satSet[`BIT_HI_CLAMP] = outClampHit[1] && chkEn_reg[`BIT_OUT_CLAMP_EN];
      satSet[`BIT_LO_CLAMP] = outClampHit[0] && chkEn_reg[`BIT_OUT_CLAMP_EN];
   end

   always_comb begin
      gen1Set = 8'h00;
      gen1Set[3:0] = serialFault & gen1En_reg[3:0];
      gen1Set[`BIT_MAP_CRC] = mapCrcBad && gen1En_reg[`BIT_MAP_CRC];
      gen1Set[`BIT_FUSE_CRC] = fuseCrcBad && gen1En_reg[`BIT_FUSE_CRC];
   end

   always_comb begin
      gen2Set = 8'h00;
      gen2Set[`BIT_RESET_DET] = resetSeenEvent && gen2En_reg[`BIT_RESET_DET];
      gen2Set[`BIT_CLK_SWITCH] = clockSwitchFailEvent;
      case (supplySel)
         SUPPLY_ANALOG: begin
            gen2Set[`BIT_AREG1] = supplyStable[2];
            gen2Set[`BIT_AREG2] = supplyStable[1];
         end
         SUPPLY_DIGITAL: begin
            gen2Set[`BIT_DREG] = supplyStable[0];
         end
         SUPPLY_ALL: begin
            gen2Set[`BIT_AREG1] = supplyStable[2];
            gen2Set[`BIT_AREG2] = supplyStable[1];
            gen2Set[`BIT_DREG] = supplyStable[0];
         end
         default: begin
            gen2Set[2:0] = 3'b000;
         end
      endcase
   end

   // flags kept only while their own check is enabled, clock switchover always kept
   always_comb begin
      satKeep = 8'h00;
      satKeep[`BIT_HI_MOD] = chkEn_reg[`BIT_MOD_EN];
      satKeep[`BIT_LO_MOD] = chkEn_reg[`BIT_MOD_EN];
      satKeep[`BIT_HI_FILTER] = chkEn_reg[`BIT_FILTER_EN];
      satKeep[`BIT_LO_FILTER] = chkEn_reg[`BIT_FILTER_EN];
      satKeep[`BIT_HI_CLAMP] = chkEn_reg[`BIT_OUT_CLAMP_EN];
      satKeep[`BIT_LO_CLAMP] = chkEn_reg[`BIT_OUT_CLAMP_EN];
      gen2Keep = 8'h00;
      gen2Keep[`BIT_RESET_DET] = gen2En_reg[`BIT_RESET_DET];
      gen2Keep[`BIT_CLK_SWITCH] = 1'b1;
      gen2Keep[`BIT_AREG1] = gen2En_reg[`SUPPLY_SEL_LSB];
      gen2Keep[`BIT_AREG2] = gen2En_reg[`SUPPLY_SEL_LSB];
      gen2Keep[`BIT_DREG] = gen2En_reg[`SUPPLY_SEL_LSB + 1];
   end

   // sticky flags, cleared by a read, set wins over clear, disabled flags forced low
   always_ff @(posedge clk) begin
      if (srst) begin
         satFlags_reg <= `RST_FLAGS;
      end else begin
         satFlags_reg <= ((rdDone && wordIndex == `IDX_SAT_FLAGS) ? 8'h00 : satFlags_reg)
            & satKeep | satSet;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gen1Flags_reg <= `RST_FLAGS;
      end else begin
         gen1Flags_reg <= ((rdDone && wordIndex == `IDX_GEN1_FLAGS) ? 8'h00 : gen1Flags_reg)
            & gen1En_reg | gen1Set;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gen2Flags_reg <= `RST_FLAGS;
      end else begin
         gen2Flags_reg <= ((rdDone && wordIndex == `IDX_GEN2_FLAGS) ? 8'h00 : gen2Flags_reg)
            & gen2Keep | (gen2Set & `GEN2_FLAG_MASK);
      end
   end

endmodule : adc_diagnostic_error_flags

// *** test/adc_diagnostic_error_flags_asserts.sv ***
`timescale 1ns/1ps
module adc_diagnostic_error_flags_asserts #(
   parameter int RAW_W = 26,
   parameter int OUT_W = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // channel side
   input wire logic [1:0] modSatEvent,
   input wire logic [1:0] filterOverEvent,
   input wire logic [1:0] resultValid,
   input wire logic [2*RAW_W-1:0] rawResult,
   input wire logic [2*OUT_W-1:0] clampedResult,
   input wire logic [1:0] clampedValid,
   // controls
   input wire logic [7:0] checkEnable,
   input wire logic [1:0] supplyMonitorSelect,
   input wire logic [1:0] tripDetectSelect
);
   localparam int MAXV = 2**(OUT_W-1)-1;
   localparam int MINV = -(2**(OUT_W-1));
   logic signed [RAW_W-1:0] rawLo;
   logic [OUT_W-1:0] clampLo;
   logic setup, isMapped, wrEn;
   assign rawLo = rawResult[RAW_W-1:0];
   assign clampLo = (rawLo > MAXV) ? MAXV[OUT_W-1:0] :
      (rawLo < MINV) ? MINV[OUT_W-1:0] : rawLo[OUT_W-1:0];
   assign setup = psel && !penable;
   assign isMapped = paddr[1:0] == 2'b00 && paddr[11:2] >= 10'h057 && paddr[11:2] <= 10'h05C;
   assign wrEn = psel && penable && pwrite && pstrb[0];
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_ready_high: assert property (pready) else $error("pready low");
   a_reset_values: assert property ($fell(srst) |-> checkEnable == 8'hFE
      && supplyMonitorSelect == 2'b11 && tripDetectSelect == 2'b00) else $error("reset controls");
   a_enable_write: assert property (wrEn && paddr == 12'h160
      |=> checkEnable == $past(pwdata[7:0])) else $error("check enables not written");
   a_select_write: assert property (wrEn && paddr == 12'h170
      |=> {supplyMonitorSelect, tripDetectSelect} == $past(pwdata[3:0])) else $error("selects");
   a_map_error: assert property (setup |=> pslverr == !$past(isMapped)) else $error("pslverr");
   a_mod_flag: assert property (modSatEvent[1] && checkEnable[5] ##1 !penable ##1
      setup && paddr == 12'h15C && checkEnable[5] |=> prdata[5]) else $error("mod flag");
   a_filter_flag: assert property (filterOverEvent[0] && checkEnable[6] ##1 !penable ##1
      setup && paddr == 12'h15C && checkEnable[6] |=> prdata[1]) else $error("filter flag");
   a_mod_disabled: assert property (setup && paddr == 12'h15C && !checkEnable[5]
      && !$past(checkEnable[5]) |=> !prdata[5] && !prdata[2]) else $error("disabled flag set");
   a_clamp_result: assert property (resultValid[0] |=> clampedValid[0]
      && clampedResult[OUT_W-1:0] == $past(clampLo)) else $error("clamp result");
   a_supply_off: assert property ((supplyMonitorSelect == 2'b00) [*8] ##1 setup
      && paddr == 12'h16C |=> prdata[2:0] == 3'b000) else $error("supply flag while off");
   c_mod_event: cover property (modSatEvent[1] && checkEnable[5]);
   c_unmapped: cover property (setup && !isMapped);
   c_clamp_high: cover property (resultValid[0] && rawLo > MAXV);
endmodule : adc_diagnostic_error_flags_asserts

// *** test/adc_diagnostic_error_flags_tb_top.sv ***
`timescale 1ns/1ps
module adc_diagnostic_error_flags_tb_top import diag_flags_pkg::*;;
   localparam int RAW_W = 26;
   localparam int OUT_W = 24;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [1:0] modSatEvent = 2'b00, filterOverEvent = 2'b00, resultValid = 2'b00;
   logic [2*RAW_W-1:0] rawResult = '0;
   logic [2*OUT_W-1:0] clampedResult;
   logic [1:0] clampedValid, supplyMonitorSelect, tripDetectSelect;
   logic [3:0] serialFault = 4'h0;
   logic [31:0] fuseData = 32'h0000_0000;
   logic [7:0] fuseCrc = 8'h00;
   logic resetSeenEvent = 1'b0, clockSwitchFailEvent = 1'b0;
   logic [2:0] supplyFaultPin = 3'b000;
   logic [7:0] checkEnable;
   int mismatches = 0, checksDone = 0, cycles = 0, seed = 21;
   // register model, flags clear on read
   byte_t mdl[6] = '{8'h00, 8'hFE, 8'h00, 8'h3E, 8'h00, 8'h3C};
   byte_t msk[6] = '{8'h00, 8'hFF, 8'h00, 8'h3F, 8'h00, 8'h3F};

   adc_diagnostic_error_flags #(.RAW_W(RAW_W), .OUT_W(OUT_W), .FUSE_W(32), .CHECK_PERIOD(16)) i_dut (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .modSatEvent(modSatEvent), .filterOverEvent(filterOverEvent), .resultValid(resultValid),
      .rawResult(rawResult), .clampedResult(clampedResult), .clampedValid(clampedValid),
      .serialFault(serialFault), .fuseData(fuseData), .fuseCrc(fuseCrc),
      .resetSeenEvent(resetSeenEvent), .clockSwitchFailEvent(clockSwitchFailEvent),
      .supplyFaultPin(supplyFaultPin), .checkEnable(checkEnable),
      .supplyMonitorSelect(supplyMonitorSelect), .tripDetectSelect(tripDetectSelect)
   );

   always #4 clk = ~clk;

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         complete_run;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input int idx, input byte_t d,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= 12'(idx * 4);
      pwdata <= {24'h00_0000, d};
      pstrb <= 4'hF;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input int i, input byte_t d);
      logic [31:0] r;
      logic e;
      apb(1'b1, 'h57 + i, d, r, e);
      if (i % 2 == 1) mdl[i] = d & msk[i];
   endtask : wr

   task automatic rdc(input int i);
      logic [31:0] r;
      logic e;
      apb(1'b0, 'h57 + i, 8'h00, r, e);
      chk("prdata", {24'h00_0000, mdl[i]}, r);
      chk("pslverr", 32'h0000_0000, {31'h0000_0000, e});
      if (i % 2 == 0) mdl[i] = 8'h00;
   endtask : rdc

   task automatic settle;
      @(posedge clk);
      modSatEvent <= 2'b00;
      filterOverEvent <= 2'b00;
      resultValid <= 2'b00;
      serialFault <= 4'h0;
      resetSeenEvent <= 1'b0;
      clockSwitchFailEvent <= 1'b0;
   endtask : settle

   initial begin : main
      logic [31:0] r;
      logic e;
      int k;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      for (k = 0; k < 6; k++) rdc(k);
      apb(1'b0, 'h56, 8'h00, r, e);
      chk("pslverr", 32'h0000_0001, {31'h0000_0000, e});
      apb(1'b1, 'h5D, 8'hAA, r, e);
      chk("pslverr", 32'h0000_0001, {31'h0000_0000, e});
      for (k = 0; k < 6; k++) begin
         wr(k, 8'($random(seed)));
         rdc(k);
      end
      wr(1, 8'hFE);
      wr(3, 8'h3E);
      wr(5, 8'h3C);
      // saturation flags, enabled then disabled
      for (k = 0; k < 12; k++) begin
         wr(1, (k < 6) ? 8'hFE : 8'hFE & ~(8'h80 >> (k % 3)));
         @(posedge clk);
         if (k % 3 == 0) begin
            rawResult <= {2{26'h0FF_FFFF}};
            resultValid[k % 6 / 3] <= 1'b1;
         end else if (k % 3 == 1) filterOverEvent[k % 6 / 3] <= 1'b1;
         else modSatEvent[k % 6 / 3] <= 1'b1;
         settle;
         if (k < 6) mdl[0][k] = 1'b1;
         rdc(0);
         rdc(0);
      end
      wr(1, 8'hFE);
      // serial faults
      for (k = 0; k < 8; k++) begin
         wr(3, (k < 4) ? 8'h3E : 8'h3F);
         @(posedge clk);
         serialFault[k % 4] <= 1'b1;
         settle;
         mdl[2][k % 4] |= mdl[3][k % 4];
         rdc(2);
      end
      fuseCrc <= 8'h01;
      repeat (40) @(posedge clk);
      fuseCrc <= 8'h00;
      repeat (40) @(posedge clk);
      mdl[2][4] = 1'b1;
      rdc(2);
      rdc(2);
      @(posedge clk);
      resetSeenEvent <= 1'b1;
      clockSwitchFailEvent <= 1'b1;
      settle;
      mdl[4] = 8'h30;
      rdc(4);
      wr(5, 8'h1C);
      @(posedge clk);
      resetSeenEvent <= 1'b1;
      settle;
      rdc(4);
      // supply monitor and trip selects
      for (k = 0; k < 4; k++) begin
         wr(5, 8'h30 | byte_t'(k * 5));
         @(negedge clk);
         chk("select", k * 5, {28'h000_0000, supplyMonitorSelect, tripDetectSelect});
         @(posedge clk);
         supplyFaultPin <= 3'b111;
         repeat (8) @(posedge clk);
         supplyFaultPin <= 3'b000;
         repeat (8) @(posedge clk);
         mdl[4] = {5'b00000, k[0], k[0], k[1]};
         rdc(4);
         rdc(4);
      end
      complete_run;
   end
endmodule : adc_diagnostic_error_flags_tb_top

bind adc_diagnostic_error_flags adc_diagnostic_error_flags_asserts #(.RAW_W(RAW_W), .OUT_W(OUT_W)) i_chk (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .modSatEvent(modSatEvent), .filterOverEvent(filterOverEvent), .resultValid(resultValid),
   .rawResult(rawResult), .clampedResult(clampedResult), .clampedValid(clampedValid),
   .checkEnable(checkEnable), .supplyMonitorSelect(supplyMonitorSelect),
   .tripDetectSelect(tripDetectSelect)
);
